//--- rtl/pim_pkg.sv
// Shared constants and types for the PCS power, reset and isolate control
// and for the MAC end that steers it over MDIO and the static config vector.
// Assumes one 25 MHz clock shared by both ends and the whole GMII.
// How it works
// - Transceiver GMII both directions on one shared clock
// - LVDS mode shares one reference clock both ends
// - No 2.5G rate over LVDS or processor MAC
// - Management registers reachable over MDIO when present
// - Ten-bit interface needs no low-power control
// - Power-down write enters low-power state
// - Low power left only by reset
// - Vector power-down, exit only by reset port
// - Come out of reset isolated from GMII
// - Software clears isolation via control register
// - Client holds vector isolate at power-on
package pim_pkg;

	// ----------------------------------------------------------------
	// Widths and timing
	// ----------------------------------------------------------------
	localparam int GMII_W       = 8;
	localparam int MD_DATA_W    = 16;
	localparam int MD_ADDR_W    = 5;
	localparam int CLK_NS       = 40;
	localparam int MDC_HALF_NS  = 200;
	// Least half period, so round up
	localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// MDIO frame
	// ----------------------------------------------------------------
	localparam logic [1:0] MD_START   = 2'h1;
	localparam logic [1:0] MD_OP_RD   = 2'h2;
	localparam logic [1:0] MD_OP_WR   = 2'h1;
	localparam logic [1:0] MD_TA_WR   = 2'h2;
	localparam logic [5:0] MD_PRE_END = 6'h1f;
	localparam logic [5:0] MD_M_TA    = 6'h2e;
	localparam logic [5:0] MD_M_DAT   = 6'h30;
	localparam logic [5:0] MD_M_LAST  = 6'h3f;
	// Slave bit counter, counted from the start bit
	localparam logic [5:0] SL_HDR_END = 6'h0c;
	localparam logic [5:0] SL_TA      = 6'h0d;
	localparam logic [5:0] SL_LOAD    = 6'h0e;
	localparam logic [5:0] SL_LAST    = 6'h1e;

	// ----------------------------------------------------------------
	// Management registers of the PCS
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_CTRL    = 5'h00;
	localparam logic [4:0] REG_STAT    = 5'h01;
	localparam int         CTL_RST_BIT = 15;
	localparam int         CTL_PD_BIT  = 11;
	localparam int         CTL_ISO_BIT = 10;
	localparam int         ST_ISO_BIT  = 0;
	localparam int         ST_PD_BIT   = 1;
	localparam int         ST_2G5_BIT  = 2;

	// ----------------------------------------------------------------
	// Avalon registers of the MAC end
	// ----------------------------------------------------------------
	localparam logic [3:0]  AV_CMD      = 4'h0;
	localparam logic [3:0]  AV_STAT     = 4'h4;
	localparam logic [3:0]  AV_CFG      = 4'h8;
	localparam int          CMD_REG_LSB = 16;
	localparam int          CMD_RD_BIT  = 24;
	localparam int          STAT_BUSY   = 16;
	localparam int          CFG_PD_BIT  = 0;
	localparam int          CFG_ISO_BIT = 1;
	localparam logic [1:0]  CFG_RST     = 2'h2;
	localparam logic [4:0]  PHY_ADDR_DEF = 5'h01;

	typedef enum logic {
		MS_IDLE = 1'b0,
		MS_BUSY = 1'b1
	} pim_mst_t;

endpackage

//--- rtl/pim_link_if.sv
// GMII, MDIO and static configuration vector between the MAC and the PCS.
// Assumes both ends clocked by the same clock; MDIO has a pull-up.
interface pim_link_if;
	import pim_pkg::*;

	logic [GMII_W-1:0] gmii_txd;
	logic              gmii_tx_en;
	logic              gmii_tx_er;
	logic [GMII_W-1:0] gmii_rxd;
	logic              gmii_rx_dv;
	logic              gmii_rx_er;
	logic              mdc;
	logic              mdio_m_o;
	logic              mdio_m_oe;
	logic              mdio_s_o;
	logic              mdio_s_oe;
	logic              mdio_in;
	logic              cfg_pdown;
	logic              cfg_isolate;

	// Pulled high when neither end drives
	assign mdio_in = mdio_m_oe ? mdio_m_o : (mdio_s_oe ? mdio_s_o : 1'b1);

	modport mac (
		output gmii_txd, gmii_tx_en, gmii_tx_er, mdc, mdio_m_o, mdio_m_oe,
		output cfg_pdown, cfg_isolate,
		input  gmii_rxd, gmii_rx_dv, gmii_rx_er, mdio_in
	);
	modport pcs (
		input  gmii_txd, gmii_tx_en, gmii_tx_er, mdc, mdio_in, cfg_pdown, cfg_isolate,
		output gmii_rxd, gmii_rx_dv, gmii_rx_er, mdio_s_o, mdio_s_oe
	);

endinterface

//--- rtl/pim_mdc_gen.sv
// Management clock divider for the MAC end.
// Assumes en_i stays high for a whole frame; mdc rests low when disabled.
module pim_mdc_gen
	import pim_pkg::*;
#(
	parameter int HALF = MDC_HALF_CYC
) (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic ce_i,
	input  wire logic en_i,
	output logic      mdc_o,
	output logic      tick_o
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       mdc;
	} pim_div_st_t;

	pim_div_st_t q;
	pim_div_st_t d;

	// Tick marks the edge at which mdc toggles
	assign tick_o = en_i && (q.cnt == 8'(HALF - 1));
	assign mdc_o  = q.mdc;

	always_comb
	begin
		d = q;
		if (!en_i)
		begin
			d.cnt = '0;
			d.mdc = 1'b0;
		end
		else if (tick_o)
		begin
			d.cnt = '0;
			d.mdc = !q.mdc;
		end
		else
		begin
			d.cnt = q.cnt + 8'h01;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= '0;
		else if (ce_i)
			q <= d;
	end

endmodule // pim_mdc_gen

//--- rtl/pim_pcs_ctrl.sv
// PCS end: MDIO management slave, power-down and isolate control, and the
// GMII gate between the MAC and the transceiver datapath.
// Assumes mdc is synchronous to mclk_i and far slower than it.
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
module pim_pcs_ctrl
	import pim_pkg::*;
#(
	parameter bit         HAS_MDIO = 1'b1,
	parameter bit         USE_XCVR = 1'b1,
	parameter bit         USE_LVDS = 1'b0,
	parameter bit         PS_MAC   = 1'b0,
	parameter bit         WANT_2G5 = 1'b0,
	parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEF
) (
	input  wire logic                       mclk_i,
	input  wire logic                       nrst_i,
	input  wire logic                       ce_i,
	pim_link_if.pcs                         lnk,
	output logic [pim_pkg::GMII_W-1:0]      xcvr_txd_o,
	output logic                            xcvr_tx_en_o,
	output logic                            xcvr_tx_er_o,
	input  wire logic [pim_pkg::GMII_W-1:0] xcvr_rxd_i,
	input  wire logic                       xcvr_rx_dv_i,
	input  wire logic                       xcvr_rx_er_i,
	output logic                            xcvr_lowpwr_o,
	output logic                            isolated_o,
	output logic                            rate_2g5_o
);
	import pim_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pim_mst_t              st;
		logic                  mdc_p;
		logic [5:0]            cnt;
		logic [12:0]           hdr;
		logic [MD_DATA_W-1:0]  sh;
		logic                  so;
		logic                  soe;
		logic                  iso;
		logic                  pd;
		logic [GMII_W-1:0]     txd;
		logic                  txen;
		logic                  txer;
		logic [GMII_W-1:0]     rxd;
		logic                  rxdv;
		logic                  rxer;
		logic                  r2g5;
	} pim_pcs_st_t;

	pim_pcs_st_t q;
	pim_pcs_st_t d;

	logic                 rise;
	logic                 hit;
	logic                 is_rd;
	logic                 is_wr;
	logic [4:0]           regad;
	logic [MD_DATA_W-1:0] rd_val;
	logic [MD_DATA_W-1:0] wr_val;
	logic                 wr_ctl;
	logic                 blocked;

	// ----------------------------------------------------------------
	// Frame decode
	// ----------------------------------------------------------------
	assign rise   = lnk.mdc && !q.mdc_p;
	assign hit    = (q.hdr[9:5] == PHY_ADDR) && (q.hdr[12] == MD_START[0]);
	assign is_rd  = hit && (q.hdr[11:10] == MD_OP_RD);
	assign is_wr  = hit && (q.hdr[11:10] == MD_OP_WR);
	assign regad  = q.hdr[4:0];
	assign wr_val = {q.sh[MD_DATA_W-2:0], lnk.mdio_in};
	assign wr_ctl = HAS_MDIO && (q.st == MS_BUSY) && rise && (q.cnt == SL_LAST)
		&& is_wr && (regad == REG_CTRL);
	// Low power blocks the datapath as firmly as isolation does
	assign blocked = q.iso || q.pd;

	always_comb
	begin
		rd_val = '0;
		if (regad == REG_CTRL)
		begin
			rd_val[CTL_PD_BIT]  = q.pd;
			rd_val[CTL_ISO_BIT] = q.iso;
		end
		else if (regad == REG_STAT)
		begin
			rd_val[ST_ISO_BIT] = q.iso;
			rd_val[ST_PD_BIT]  = q.pd;
			rd_val[ST_2G5_BIT] = q.r2g5;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.mdc_p = lnk.mdc;

		// MDIO slave, only when the management port exists
		unique case (q.st)
			MS_IDLE:
			begin
				if (HAS_MDIO && rise && !lnk.mdio_in)
				begin
					d.st  = MS_BUSY;
					d.cnt = '0;
				end
			end
			MS_BUSY:
			begin
				if (rise)
				begin
					d.cnt = q.cnt + 6'h01;
					if (q.cnt <= SL_HDR_END)
						d.hdr = {q.hdr[11:0], lnk.mdio_in};
					else if (q.cnt == SL_TA)
					begin
						// Second turnaround bit is driven low by the slave
						d.soe = is_rd;
						d.so  = 1'b0;
					end
					else if (q.cnt == SL_LOAD)
					begin
						d.so = rd_val[MD_DATA_W-1];
						d.sh = {rd_val[MD_DATA_W-2:0], 1'b0};
					end
					else if (q.cnt == SL_LAST)
					begin
						d.soe = 1'b0;
						d.st  = MS_IDLE;
					end
					else if (is_rd)
					begin
						d.so = q.sh[MD_DATA_W-1];
						d.sh = {q.sh[MD_DATA_W-2:0], 1'b0};
					end
					else
					begin
						d.sh = wr_val;
					end
				end
			end
		endcase

		// Power and isolation; power-down is sticky until a reset
		if (HAS_MDIO)
		begin
			if (wr_ctl && wr_val[CTL_RST_BIT])
			begin
				d.iso = 1'b1;
				d.pd  = 1'b0;
			end
			else if (wr_ctl)
			begin
				d.iso = wr_val[CTL_ISO_BIT];
				d.pd  = q.pd || (USE_XCVR && wr_val[CTL_PD_BIT]);
			end
		end
		else
		begin
			d.iso = lnk.cfg_isolate;
			d.pd  = q.pd || (USE_XCVR && lnk.cfg_pdown);
		end

		// Rate capability is fixed by the attachment
		d.r2g5 = WANT_2G5 && USE_XCVR && !USE_LVDS && !PS_MAC;

		// Both directions move on the one shared clock
		d.txd  = blocked ? '0 : lnk.gmii_txd;
		d.txen = !blocked && lnk.gmii_tx_en;
		d.txer = !blocked && lnk.gmii_tx_er;
		d.rxd  = blocked ? '0 : xcvr_rxd_i;
		d.rxdv = !blocked && xcvr_rx_dv_i;
		d.rxer = !blocked && xcvr_rx_er_i;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			q       <= '0;
			q.iso   <= 1'b1;
			q.mdc_p <= 1'b0;
		end
		else if (ce_i)
		begin
			q <= d;
		end
	end

	assign lnk.mdio_s_o  = q.so;
	assign lnk.mdio_s_oe = q.soe;
	assign lnk.gmii_rxd  = q.rxd;
	assign lnk.gmii_rx_dv = q.rxdv;
	assign lnk.gmii_rx_er = q.rxer;
	assign xcvr_txd_o    = q.txd;
	assign xcvr_tx_en_o  = q.txen;
	assign xcvr_tx_er_o  = q.txer;
	assign xcvr_lowpwr_o = q.pd;
	assign isolated_o    = q.iso;
	assign rate_2g5_o    = q.r2g5;

endmodule // pim_pcs_ctrl

//--- rtl/pim_mac_end.sv
// MAC end: Avalon-MM slave with waitrequest, MDIO master, config vector,
// and the GMII datapath registers toward the PCS.
// Assumes the Avalon master holds a request until it sees waitrequest low.
module pim_mac_end
	import pim_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEF
) (
	input  wire logic                       mclk_i,
	input  wire logic                       nrst_i,
	input  wire logic                       ce_i,
	input  wire logic [3:0]                 avs_address_i,
	input  wire logic                       avs_read_i,
	input  wire logic                       avs_write_i,
	input  wire logic [31:0]                avs_writedata_i,
	output logic [31:0]                     avs_readdata_o,
	output logic                            avs_waitrequest_o,
	input  wire logic [pim_pkg::GMII_W-1:0] tx_data_i,
	input  wire logic                       tx_en_i,
	input  wire logic                       tx_er_i,
	output logic [pim_pkg::GMII_W-1:0]      rx_data_o,
	output logic                            rx_dv_o,
	output logic                            rx_er_o,
	pim_link_if.mac                         lnk
);
	import pim_pkg::*;

	typedef struct packed {
		pim_mst_t             st;
		logic                 wt;
		logic [31:0]          rdata;
		logic [5:0]           cnt;
		logic [31:0]          frame;
		logic                 rd;
		logic                 mo;
		logic                 moe;
		logic [MD_DATA_W-1:0] rsh;
		logic [MD_DATA_W-1:0] last;
		logic [1:0]           cfg;
		logic [GMII_W-1:0]    txd;
		logic                 txen;
		logic                 txer;
		logic [GMII_W-1:0]    rxd;
		logic                 rxdv;
		logic                 rxer;
	} pim_mac_st_t;

	pim_mac_st_t q;
	pim_mac_st_t d;

	logic        mdc;
	logic        tick;
	logic [5:0]  nb;
	logic [31:0] rmux;
	logic        cmd_busy;

	pim_mdc_gen #(.HALF(MDC_HALF_CYC)) u_mdc (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.ce_i   (ce_i),
		.en_i   (q.st == MS_BUSY),
		.mdc_o  (mdc),
		.tick_o (tick)
	);

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	assign nb       = q.cnt + 6'h01;
	assign cmd_busy = avs_write_i && (avs_address_i == AV_CMD) && (q.st == MS_BUSY);

	always_comb
	begin
		rmux = '0;
		if (avs_address_i == AV_STAT)
		begin
			rmux[MD_DATA_W-1:0] = q.last;
			rmux[STAT_BUSY]     = (q.st == MS_BUSY);
		end
		else if (avs_address_i == AV_CFG)
		begin
			rmux[1:0] = q.cfg;
		end
	end

	always_comb
	begin
		d = q;
		d.txd  = tx_data_i;
		d.txen = tx_en_i;
		d.txer = tx_er_i;
		d.rxd  = lnk.gmii_rxd;
		d.rxdv = lnk.gmii_rx_dv;
		d.rxer = lnk.gmii_rx_er;

		// Answer one cycle after the request; a command while busy stalls
		d.wt = 1'b1;
		if (q.wt && (avs_read_i || avs_write_i) && !cmd_busy)
		begin
			d.wt    = 1'b0;
			d.rdata = rmux;
		end

		unique case (q.st)
			MS_IDLE:
			begin
				if (!q.wt && avs_write_i && (avs_address_i == AV_CMD))
				begin
					d.st    = MS_BUSY;
					d.rd    = avs_writedata_i[CMD_RD_BIT];
					d.frame = {MD_START,
						avs_writedata_i[CMD_RD_BIT] ? MD_OP_RD : MD_OP_WR,
						PHY_ADDR, avs_writedata_i[CMD_REG_LSB +: MD_ADDR_W],
						MD_TA_WR, avs_writedata_i[MD_DATA_W-1:0]};
					d.cnt   = '0;
					d.mo    = 1'b1;
					d.moe   = 1'b1;
				end
			end
			MS_BUSY:
			begin
				if (tick && !mdc)
				begin
					// Rising mdc: sample read data
					if (q.cnt >= MD_M_DAT)
						d.rsh = {q.rsh[MD_DATA_W-2:0], lnk.mdio_in};
					if (q.cnt == MD_M_LAST)
					begin
						d.st  = MS_IDLE;
						d.moe = 1'b0;
						if (q.rd)
							d.last = {q.rsh[MD_DATA_W-2:0], lnk.mdio_in};
					end
				end
				else if (tick)
				begin
					// Falling mdc: present the next bit
					d.cnt = nb;
					d.mo  = (nb <= MD_PRE_END) ? 1'b1 : q.frame[5'(MD_M_LAST - nb)];
					d.moe = !(q.rd && (nb >= MD_M_TA));
				end
			end
		endcase

		if (!q.wt && avs_write_i && (avs_address_i == AV_CFG))
			d.cfg = avs_writedata_i[1:0];
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			q     <= '0;
			q.wt  <= 1'b1;
			q.cfg <= CFG_RST;
		end
		else if (ce_i)
		begin
			q <= d;
		end
	end

	assign avs_readdata_o    = q.rdata;
	assign avs_waitrequest_o = q.wt;
	assign rx_data_o         = q.rxd;
	assign rx_dv_o           = q.rxdv;
	assign rx_er_o           = q.rxer;
	assign lnk.gmii_txd      = q.txd;
	assign lnk.gmii_tx_en    = q.txen;
	assign lnk.gmii_tx_er    = q.txer;
	assign lnk.mdc           = mdc;
	assign lnk.mdio_m_o      = q.mo;
	assign lnk.mdio_m_oe     = q.moe;
	assign lnk.cfg_pdown     = q.cfg[CFG_PD_BIT];
	assign lnk.cfg_isolate   = q.cfg[CFG_ISO_BIT];

endmodule // pim_mac_end

//--- dv/pim_link_asserts.sv
// Concurrent checks on the link between the MAC end and the PCS end.
// Assumes one clock and one async active-low reset shared by both ends.
module pim_link_asserts (
	input wire logic                       mclk_i,
	input wire logic                       nrst_i,
	input wire logic [pim_pkg::GMII_W-1:0] gmii_rxd,
	input wire logic                       gmii_rx_dv,
	input wire logic                       gmii_rx_er,
	input wire logic                       mdc,
	input wire logic                       mdio_m_oe,
	input wire logic                       mdio_s_oe,
	input wire logic                       cfg_isolate,
	input wire logic                       xcvr_tx_en_o,
	input wire logic                       xcvr_lowpwr_o,
	input wire logic                       isolated_o
);
	import pim_pkg::*;

	// Cycles since the MAC last drove MDIO; state may only drop after a frame
	logic [3:0] since_oe_q;

	always_ff @(posedge mclk_i or negedge nrst_i)
		if (!nrst_i)
			since_oe_q <= 4'hf;
		else if (mdio_m_oe)
			since_oe_q <= 4'h0;
		else if (since_oe_q != 4'hf)
			since_oe_q <= since_oe_q + 4'h1;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	property p_rx_iso;
		isolated_o [*3] |-> gmii_rx_dv == 1'b0 && gmii_rx_er == 1'b0 && gmii_rxd == '0;
	endproperty
	a_rx_iso: assert property (p_rx_iso) else $error("rx not idle while isolated");
	property p_tx_iso;
		isolated_o [*3] |-> !xcvr_tx_en_o;
	endproperty
	a_tx_iso: assert property (p_tx_iso) else $error("tx passed while isolated");
	property p_pd_gate;
		xcvr_lowpwr_o [*3] |-> !gmii_rx_dv && !xcvr_tx_en_o;
	endproperty
	a_pd_gate: assert property (p_pd_gate) else $error("traffic in low power");
	property p_pd_exit;
		$fell(xcvr_lowpwr_o) |-> since_oe_q < 4'hc;
	endproperty
	a_pd_exit: assert property (p_pd_exit) else $error("low power left unbidden");
	property p_iso_exit;
		$fell(isolated_o) |-> since_oe_q < 4'hc;
	endproperty
	a_iso_exit: assert property (p_iso_exit) else $error("isolation left unbidden");
	property p_boot_iso;
		$rose(nrst_i) |-> isolated_o && cfg_isolate;
	endproperty
	a_boot_iso: assert property (p_boot_iso) else $error("not isolated at start");
	property p_one_drv;
		!(mdio_m_oe && mdio_s_oe);
	endproperty
	a_one_drv: assert property (p_one_drv) else $error("both ends drive mdio");
	// The closing rise of a frame lasts one cycle, as the divider stops at once;
	// any longer high time must be the full half period
	property p_mdc_half;
		$rose(mdc) ##1 mdc |-> mdc [*4] ##1 !mdc;
	endproperty
	a_mdc_half: assert property (p_mdc_half) else $error("mdc high time wrong");
endmodule // pim_link_asserts

//--- dv/pcs_power_isolate_control_bench.sv
// Bench: MAC end and PCS end joined by the link, plus two PCS ends without
// management whose vectors are driven here. Assumes rtl/ compiled first.
module pcs_power_isolate_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import pim_pkg::*;

	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [3:0]  avs_address_i = 4'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic [7:0]  tx_data_i = 8'h0;
	logic        tx_en_i = 1'b0;
	logic [7:0]  rx_data_o;
	logic        rx_dv_o;
	logic [7:0]  xrx_d = 8'h0;
	logic        xrx_dv = 1'b0;
	logic [7:0]  xtx_d;
	logic        xtx_en, lowpwr, iso, r2g5, lowpwr2;
	logic        ce = 1'b1;
	logic        tx_er_i = 1'b0;
	logic        xrx_er = 1'b0;
	logic        rx_er_o, xtx_er, iso2, lowpwr3;
	int          n_errors = 0;
	int          num_checks = 0;
	int          cycles = 0;
	logic [31:0] rng = 32'h93f7;
	logic [31:0] rd;

	pim_link_if lnk ();
	pim_link_if lnk2 ();
	pim_link_if lnk3 ();
	pim_mac_end i_pim_mac_end (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .tx_data_i(tx_data_i), .tx_en_i(tx_en_i),
		.tx_er_i(tx_er_i), .rx_data_o(rx_data_o), .rx_dv_o(rx_dv_o), .rx_er_o(rx_er_o),
		.lnk(lnk));
	pim_pcs_ctrl i_pim_pcs_ctrl (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce), .lnk(lnk),
		.xcvr_txd_o(xtx_d), .xcvr_tx_en_o(xtx_en), .xcvr_tx_er_o(xtx_er), .xcvr_rxd_i(xrx_d),
		.xcvr_rx_dv_i(xrx_dv), .xcvr_rx_er_i(xrx_er), .xcvr_lowpwr_o(lowpwr),
		.isolated_o(iso), .rate_2g5_o(r2g5));
	pim_pcs_ctrl #(.HAS_MDIO(1'b0)) i_pim_pcs_ctrl_vec (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.ce_i(ce), .lnk(lnk2), .xcvr_txd_o(), .xcvr_tx_en_o(), .xcvr_tx_er_o(),
		.xcvr_rxd_i(xrx_d), .xcvr_rx_dv_i(xrx_dv), .xcvr_rx_er_i(xrx_er),
		.xcvr_lowpwr_o(lowpwr2), .isolated_o(iso2), .rate_2g5_o());
	// Ten-bit attachment: no low-power control at all
	pim_pcs_ctrl #(.HAS_MDIO(1'b0), .USE_XCVR(1'b0)) i_pim_pcs_ctrl_tbi (.mclk_i(mclk_i),
		.nrst_i(nrst_i), .ce_i(ce), .lnk(lnk3), .xcvr_txd_o(), .xcvr_tx_en_o(),
		.xcvr_tx_er_o(), .xcvr_rxd_i(xrx_d), .xcvr_rx_dv_i(xrx_dv), .xcvr_rx_er_i(xrx_er),
		.xcvr_lowpwr_o(lowpwr3), .isolated_o(), .rate_2g5_o());
	pim_link_asserts i_pim_link_asserts (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.gmii_rxd(lnk.gmii_rxd), .gmii_rx_dv(lnk.gmii_rx_dv), .gmii_rx_er(lnk.gmii_rx_er),
		.mdc(lnk.mdc), .mdio_m_oe(lnk.mdio_m_oe), .mdio_s_oe(lnk.mdio_s_oe),
		.cfg_isolate(lnk.cfg_isolate), .xcvr_tx_en_o(xtx_en), .xcvr_lowpwr_o(lowpwr),
		.isolated_o(iso));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic report_and_stop();
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask

	// Request held until waitrequest is seen low; the global timeout bounds it
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		@(posedge mclk_i);
		while (avs_waitrequest_o !== 1'b0)
			@(posedge mclk_i);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic mdio(input logic rdn, input logic [4:0] r, input logic [15:0] d);
		av(1'b1, AV_CMD, {7'h0, rdn, 3'h0, r, d});
		rd = 32'h0001_0000;
		while (rd[STAT_BUSY] !== 1'b0)
			av(1'b0, AV_STAT, 32'h0);
	endtask

	// Random traffic both ways; when open each path shows its input two edges late
	task automatic traffic(input logic open);
		logic [19:0] hist [$];
		repeat (24)
		begin
			@(posedge mclk_i);
			rng = xs(rng);
			tx_data_i <= rng[7:0];
			tx_en_i <= rng[8];
			tx_er_i <= rng[9];
			xrx_d <= rng[17:10];
			xrx_dv <= rng[18];
			xrx_er <= rng[19];
			hist.push_front(rng[19:0]);
			@(negedge mclk_i);
			if (hist.size() > 2)
				chk("gmii path", 32'(open ? hist[2] : 20'h0),
					32'({rx_er_o, rx_dv_o, rx_data_o, xtx_er, xtx_en, xtx_d}));
		end
	endtask

	initial forever #20 mclk_i = ~mclk_i;

	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	initial
	begin
		{lnk2.gmii_txd, lnk2.gmii_tx_en, lnk2.gmii_tx_er, lnk2.mdc} = '0;
		{lnk2.mdio_m_oe, lnk2.cfg_pdown, lnk2.mdio_m_o, lnk2.cfg_isolate} = 4'h3;
		{lnk3.gmii_txd, lnk3.gmii_tx_en, lnk3.gmii_tx_er, lnk3.mdc} = '0;
		{lnk3.mdio_m_oe, lnk3.cfg_pdown, lnk3.mdio_m_o, lnk3.cfg_isolate} = 4'h3;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge mclk_i);
		nrst_i <= 1'b1;
		wt(0);
		chk("isolated", 32'h1, 32'(iso));
		chk("lowpwr", 32'h0, 32'(lowpwr));
		chk("rate 2g5", 32'h0, 32'(r2g5));
		av(1'b0, AV_CFG, 32'h0);
		chk("cfg vector", 32'h2, rd);
		av(1'b1, 4'hc, 32'hffff_ffff);
		av(1'b0, 4'hc, 32'h0);
		chk("unmapped", 32'h0, rd);
		traffic(1'b0);
		mdio(1'b1, REG_STAT, 16'h0);
		chk("status iso", 32'h1, 32'(rd[15:0]));
		mdio(1'b0, REG_CTRL, 16'h0);
		wt(4);
		chk("isolated", 32'h0, 32'(iso));
		traffic(1'b1);
		mdio(1'b0, REG_CTRL, 16'h0800);
		wt(4);
		chk("lowpwr", 32'h1, 32'(lowpwr));
		mdio(1'b1, REG_STAT, 16'h0);
		chk("status pd", 32'h2, 32'(rd[15:0]));
		traffic(1'b0);
		mdio(1'b0, REG_CTRL, 16'h0);
		wt(4);
		chk("lowpwr", 32'h1, 32'(lowpwr));
		mdio(1'b0, REG_CTRL, 16'h8000);
		wt(4);
		chk("lowpwr", 32'h0, 32'(lowpwr));
		chk("isolated", 32'h1, 32'(iso));
		// A request that comes and goes while the clock enable is low is lost
		@(posedge mclk_i);
		ce <= 1'b0;
		lnk2.cfg_pdown <= 1'b1;
		repeat (3) @(posedge mclk_i);
		lnk2.cfg_pdown <= 1'b0;
		@(posedge mclk_i);
		ce <= 1'b1;
		wt(2);
		chk("frozen lowpwr", 32'h0, 32'(lowpwr2));
		@(posedge mclk_i);
		lnk2.cfg_pdown <= 1'b1;
		lnk3.cfg_pdown <= 1'b1;
		@(posedge mclk_i);
		lnk2.cfg_pdown <= 1'b0;
		lnk3.cfg_pdown <= 1'b0;
		wt(4);
		chk("vector lowpwr", 32'h1, 32'(lowpwr2));
		chk("tbi lowpwr", 32'h0, 32'(lowpwr3));
		@(posedge mclk_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1'b1;
		wt(0);
		chk("vector lowpwr", 32'h0, 32'(lowpwr2));
		chk("isolated", 32'h1, 32'(iso));
		chk("vector iso", 32'h1, 32'(iso2));
		report_and_stop();
	end
endmodule // pcs_power_isolate_control_bench
